// ===== hdl/ltm_regs.svh
// Register offsets, field positions, reset values and timing counts for the LED test/mapping register bank
`ifndef LTM_REGS_SVH
`define LTM_REGS_SVH

// Register offsets
`define LTM_STATUS_IRQ_ADDR      8'h3a
`define LTM_TEMP_CTRL_ADDR       8'h3e
`define LTM_INT_TEMP_ADDR        8'h3f
`define LTM_EXT_TEMP_ADDR        8'h40
`define LTM_TEST_CTRL_ADDR       8'h41
`define LTM_TEST_RESULT_ADDR     8'h42
`define LTM_ENG1_VAR_ADDR        8'h45
`define LTM_ENG2_VAR_ADDR        8'h46
`define LTM_ENG3_VAR_ADDR        8'h47
`define LTM_DIM1_ADDR            8'h48
`define LTM_DIM2_ADDR            8'h49
`define LTM_DIM3_ADDR            8'h4a
`define LTM_BASE1_ADDR           8'h4c
`define LTM_BASE2_ADDR           8'h4d
`define LTM_BASE3_ADDR           8'h4e
`define LTM_PAGE_ADDR            8'h4f
`define LTM_MAP1_HI_ADDR         8'h70
`define LTM_MAP1_LO_ADDR         8'h71
`define LTM_MAP2_HI_ADDR         8'h72
`define LTM_MAP2_LO_ADDR         8'h73
`define LTM_MAP3_HI_ADDR         8'h74
`define LTM_MAP3_LO_ADDR         8'h75
`define LTM_GAIN_CTRL_ADDR       8'h76

// Field positions
`define LTM_SRC_SEL_BIT          0
`define LTM_DONE_BIT             7
`define LTM_FIRE_BIT             7
`define LTM_IRQ_EN_BIT           6
`define LTM_REPEAT_BIT           5
`define LTM_CHAN_MSB             4
`define LTM_THRESH_MSB           7
`define LTM_THRESH_LSB           6
`define LTM_ADAPT_BIT            5
`define LTM_BASE_MSB             6
`define LTM_PAGE_MSB             2

// Values
`define LTM_TEMP_MAX             8'h59
`define LTM_TEMP_MIN             8'hd9
`define LTM_CHAN_LAST_LED        5'h08
`define LTM_CHAN_PUMP            5'h0f
`define LTM_CHAN_SUPPLY          5'h10
`define LTM_CHAN_INT_PIN         5'h11
`define LTM_PAGE_COUNT           3'h6
`define LTM_RESET_BYTE           8'h00

// Timing
`define LTM_CLK_MHZ              20
`define LTM_MEAS_TIME_US         2700
`define LTM_MEAS_CYCLES          (`LTM_MEAS_TIME_US * `LTM_CLK_MHZ)

`endif

// ===== hdl/ltm_pkg.sv
// Types for the LED test/mapping register bank
package ltm_pkg;
   typedef enum logic [0:0] {
      LTM_MEAS_IDLE = 1'b0,
      LTM_MEAS_RUN  = 1'b1
   } ltm_meas_e;
endpackage

// ===== hdl/ltm_bank.sv
// LED test, temperature source, group dimmer, code memory and pump gain register bank
`timescale 1ns/100ps
`include "ltm_regs.svh"

module ltm_bank
   import ltm_pkg::*;
#(
   parameter int unsigned MEAS_CYCLES = `LTM_MEAS_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // Register port from the serial bus front end
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Temperature
   input  wire logic        sensor_temp_valid,
   input  wire logic [7:0]  sensor_temp,
   output logic      [7:0]  comp_temp,
   // Voltage measurement front end
   input  wire logic        power_save,
   input  wire logic [7:0]  adc_code,
   output logic      [4:0]  measure_channel_sel,
   output logic             measure_channel_valid,
   output logic             measure_active,
   // Engines
   input  wire logic [23:0] eng_local_var,
   input  wire logic [26:0] eng_output_map,
   output logic      [20:0] eng_code_base,
   output logic      [2:0]  code_page_sel,
   // Group dimming
   input  wire logic [71:0] led_pwm_in,
   input  wire logic [17:0] led_group_sel,
   output logic      [71:0] led_pwm_out,
   // Charge pump
   input  wire logic [1:0]  factory_threshold,
   output logic      [1:0]  pump_threshold,
   output logic             adaptive_hysteresis_en,
   // Interrupt pin, open drain
   output logic             irq_pin_o,
   output logic             irq_pin_oe_n
);

   localparam logic [16:0] MEAS_LAST = 17'(MEAS_CYCLES - 1);

   logic            outside_temp_source_sel;
   logic [7:0]      internal_temperature_reg;
   logic [7:0]      external_temperature_reg;
   logic            voltage_measure_irq_en;
   logic            repeat_measure_en;
   logic [4:0]      chan_reg;
   logic [7:0]      measure_result_code;
   logic            measure_done_flag;
   logic            irq_pending_reg;
   logic [7:0]      dim_reg [3];
   logic [6:0]      base_reg [3];
   logic [2:0]      page_reg;
   logic [1:0]      thresh_reg;
   logic            thresh_override_reg;
   logic            adaptive_reg;
   ltm_meas_e       meas_state;
   logic [16:0]     meas_cnt;
   logic            meas_end;
   logic            status_read;
   logic [7:0]      clamped_temp;
   logic [7:0]      rdata_next;

   assign status_read = reg_rd && (reg_addr == `LTM_STATUS_IRQ_ADDR);
   assign meas_end    = (meas_state == LTM_MEAS_RUN) && (meas_cnt == MEAS_LAST);

   // Signed clamp of host-written temperature
   always_comb begin
      clamped_temp = reg_wdata;
      if ($signed(reg_wdata) > $signed(`LTM_TEMP_MAX)) begin
         clamped_temp = `LTM_TEMP_MAX;
      end else if ($signed(reg_wdata) < $signed(`LTM_TEMP_MIN)) begin
         clamped_temp = `LTM_TEMP_MIN;
      end
   end

   // Internal reading comes only from the sensor; host writes never reach it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         internal_temperature_reg <= `LTM_RESET_BYTE;
      end else if (sensor_temp_valid) begin
         internal_temperature_reg <= sensor_temp;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         outside_temp_source_sel <= 1'b0;
      end else if (reg_wr && reg_addr == `LTM_TEMP_CTRL_ADDR) begin
         outside_temp_source_sel <= reg_wdata[`LTM_SRC_SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         external_temperature_reg <= `LTM_RESET_BYTE;
      end else if (reg_wr && reg_addr == `LTM_EXT_TEMP_ADDR) begin
         external_temperature_reg <= clamped_temp;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         comp_temp <= `LTM_RESET_BYTE;
      end else begin
         comp_temp <= outside_temp_source_sel ? external_temperature_reg : internal_temperature_reg;
      end
   end

   // Test control register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         voltage_measure_irq_en <= 1'b0;
         repeat_measure_en      <= 1'b0;
         chan_reg               <= 5'h00;
      end else if (reg_wr && reg_addr == `LTM_TEST_CTRL_ADDR) begin
         voltage_measure_irq_en <= reg_wdata[`LTM_IRQ_EN_BIT];
         repeat_measure_en      <= reg_wdata[`LTM_REPEAT_BIT];
         chan_reg               <= reg_wdata[`LTM_CHAN_MSB:0];
      end
   end

   // Channel decode toward the analog mux; reserved codes pass through to measure_channel_sel with measure_channel_valid low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         measure_channel_sel   <= 5'h00;
         measure_channel_valid <= 1'b0;
      end else begin
         measure_channel_sel   <= chan_reg;
         measure_channel_valid <= (chan_reg <= `LTM_CHAN_LAST_LED) || (chan_reg == `LTM_CHAN_PUMP) ||
                                  (chan_reg == `LTM_CHAN_SUPPLY) || (chan_reg == `LTM_CHAN_INT_PIN);
      end
   end

   // Conversion sequencer; a fire during a running conversion is ignored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meas_state <= LTM_MEAS_IDLE;
         meas_cnt   <= 17'h00000;
      end else begin
         unique case (meas_state)
            LTM_MEAS_IDLE: begin
               meas_cnt <= 17'h00000;
               if (reg_wr && reg_addr == `LTM_TEST_CTRL_ADDR && reg_wdata[`LTM_FIRE_BIT]) begin
                  meas_state <= LTM_MEAS_RUN;
               end
            end
            LTM_MEAS_RUN: begin
               if (meas_end) begin
                  meas_cnt <= 17'h00000;
                  if (!repeat_measure_en || power_save) begin
                     meas_state <= LTM_MEAS_IDLE;
                  end
               end else begin
                  meas_cnt <= meas_cnt + 17'h00001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         measure_active <= 1'b0;
      end else begin
         measure_active <= (meas_state == LTM_MEAS_RUN) && !meas_end;
      end
   end

   // Result taken at every conversion end, reserved channels included
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         measure_result_code <= `LTM_RESET_BYTE;
      end else if (meas_end) begin
         measure_result_code <= adc_code;
      end
   end

   // Completion in the read cycle wins over the clear, so no result goes unseen
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         measure_done_flag <= 1'b0;
      end else if (meas_end) begin
         measure_done_flag <= 1'b1;
      end else if (status_read) begin
         measure_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_pending_reg <= 1'b0;
      end else if (meas_end && voltage_measure_irq_en) begin
         irq_pending_reg <= 1'b1;
      end else if (status_read) begin
         irq_pending_reg <= 1'b0;
      end
   end

   // Pin driven low only while pending; external pull-up gives the high level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_pin_o    <= 1'b0;
         irq_pin_oe_n <= 1'b1;
      end else begin
         irq_pin_o    <= 1'b0;
         irq_pin_oe_n <= !irq_pending_reg;
      end
   end

   // Dimmers and code base registers, one per group or engine
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_grp
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               dim_reg[g]  <= `LTM_RESET_BYTE;
               base_reg[g] <= 7'h00;
            end else if (reg_wr) begin
               if (reg_addr == `LTM_DIM1_ADDR + 8'(g)) begin
                  dim_reg[g] <= reg_wdata;
               end
               if (reg_addr == `LTM_BASE1_ADDR + 8'(g)) begin
                  base_reg[g] <= reg_wdata[`LTM_BASE_MSB:0];
               end
            end
         end
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               eng_code_base[g*7 +: 7] <= 7'h00;
            end else begin
               eng_code_base[g*7 +: 7] <= base_reg[g];
            end
         end
      end
   endgenerate

   // Per-output scaling by the group dimmer the output is mapped to; 0 means no group
   genvar l;
   generate
      for (l = 0; l < 9; l++) begin : gen_led
         logic [1:0]  grp;
         logic [15:0] prod;
         assign grp  = led_group_sel[l*2 +: 2];
         assign prod = (grp == 2'h0) ? {led_pwm_in[l*8 +: 8], 8'h00} :
                       16'(led_pwm_in[l*8 +: 8] * dim_reg[grp - 2'h1]);
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               led_pwm_out[l*8 +: 8] <= 8'h00;
            end else begin
               led_pwm_out[l*8 +: 8] <= prod[15:8];
            end
         end
      end
   endgenerate

   // Page select; codes beyond the last page are refused
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         page_reg      <= 3'h0;
         code_page_sel <= 3'h0;
      end else begin
         if (reg_wr && reg_addr == `LTM_PAGE_ADDR && reg_wdata[`LTM_PAGE_MSB:0] < `LTM_PAGE_COUNT) begin
            page_reg <= reg_wdata[`LTM_PAGE_MSB:0];
         end
         code_page_sel <= page_reg;
      end
   end

   // Pump gain control
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thresh_reg <= 2'h0;
      end else if (reg_wr && reg_addr == `LTM_GAIN_CTRL_ADDR) begin
         thresh_reg <= reg_wdata[`LTM_THRESH_MSB:`LTM_THRESH_LSB];
      end
   end

   // Any write claims the threshold from the factory code, whatever data it carries
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         thresh_override_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `LTM_GAIN_CTRL_ADDR) begin
         thresh_override_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         adaptive_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `LTM_GAIN_CTRL_ADDR) begin
         adaptive_reg <= reg_wdata[`LTM_ADAPT_BIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pump_threshold <= 2'h0;
      end else begin
         pump_threshold <= thresh_override_reg ? thresh_reg : factory_threshold;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         adaptive_hysteresis_en <= 1'b0;
      end else begin
         adaptive_hysteresis_en <= adaptive_reg;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = `LTM_RESET_BYTE;
      unique case (reg_addr)
         `LTM_STATUS_IRQ_ADDR:  rdata_next[`LTM_DONE_BIT] = measure_done_flag;
         `LTM_TEMP_CTRL_ADDR:   rdata_next[`LTM_SRC_SEL_BIT] = outside_temp_source_sel;
         `LTM_INT_TEMP_ADDR:    rdata_next = internal_temperature_reg;
         `LTM_EXT_TEMP_ADDR:    rdata_next = external_temperature_reg;
         `LTM_TEST_CTRL_ADDR:   rdata_next = {meas_state == LTM_MEAS_RUN, voltage_measure_irq_en,
                                              repeat_measure_en, chan_reg};
         `LTM_TEST_RESULT_ADDR: rdata_next = measure_result_code;
         `LTM_ENG1_VAR_ADDR:    rdata_next = eng_local_var[7:0];
         `LTM_ENG2_VAR_ADDR:    rdata_next = eng_local_var[15:8];
         `LTM_ENG3_VAR_ADDR:    rdata_next = eng_local_var[23:16];
         `LTM_DIM1_ADDR:        rdata_next = dim_reg[0];
         `LTM_DIM2_ADDR:        rdata_next = dim_reg[1];
         `LTM_DIM3_ADDR:        rdata_next = dim_reg[2];
         `LTM_BASE1_ADDR:       rdata_next = {1'b0, base_reg[0]};
         `LTM_BASE2_ADDR:       rdata_next = {1'b0, base_reg[1]};
         `LTM_BASE3_ADDR:       rdata_next = {1'b0, base_reg[2]};
         `LTM_PAGE_ADDR:        rdata_next = {5'h00, page_reg};
         `LTM_MAP1_HI_ADDR:     rdata_next = {7'h00, eng_output_map[8]};
         `LTM_MAP1_LO_ADDR:     rdata_next = eng_output_map[7:0];
         `LTM_MAP2_HI_ADDR:     rdata_next = {7'h00, eng_output_map[17]};
         `LTM_MAP2_LO_ADDR:     rdata_next = eng_output_map[16:9];
         `LTM_MAP3_HI_ADDR:     rdata_next = {7'h00, eng_output_map[26]};
         `LTM_MAP3_LO_ADDR:     rdata_next = eng_output_map[25:18];
         // Factory threshold stays hidden: reads show only what the host wrote
         `LTM_GAIN_CTRL_ADDR:   rdata_next = {thresh_reg, adaptive_reg, 5'h00};
         default:               rdata_next = `LTM_RESET_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= `LTM_RESET_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

endmodule

// ===== sim/ltm_bank_monitor.sv
// Concurrent checks on the ports of the LED test register bank
`timescale 1ns/100ps
module ltm_bank_monitor #(
   parameter int unsigned MEAS_CYCLES = 20
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   // Temperature
   input wire logic       sensor_temp_valid,
   input wire logic [7:0] sensor_temp,
   input wire logic [7:0] comp_temp,
   // Measurement, code page, pump, interrupt
   input wire logic [4:0] measure_channel_sel,
   input wire logic       measure_channel_valid,
   input wire logic       measure_active,
   input wire logic [2:0] code_page_sel,
   input wire logic [1:0] pump_threshold,
   input wire logic       adaptive_hysteresis_en,
   input wire logic       irq_pin_o,
   input wire logic       irq_pin_oe_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   int unsigned run_cnt;
   wire st_rd = reg_rd && reg_addr == 8'h3a;
   // Length of each unbroken busy stretch
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) run_cnt <= 0;
      else run_cnt <= measure_active ? run_cnt + 1 : 0;
   end
   AST_IRQ_DRIVE_LOW: assert property (!irq_pin_oe_n |-> !irq_pin_o)
      else $error("interrupt pin driven high");
   AST_MEAS_LENGTH: assert property ($fell(measure_active) |-> run_cnt == MEAS_CYCLES - 1)
      else $error("conversion length wrong");
   AST_IRQ_CAUSE: assert property ($fell(irq_pin_oe_n) |-> $past(measure_active, 2))
      else $error("interrupt without completed conversion");
   AST_IRQ_CLEAR: assert property (st_rd && !measure_active |-> ##2 irq_pin_oe_n)
      else $error("status read did not release interrupt");
   AST_IRQ_HOLD: assert property (!irq_pin_oe_n && !st_rd |=> !irq_pin_oe_n || $past(st_rd, 2))
      else $error("interrupt released without status read");
   AST_CHAN_VALID: assert property ($past(nrst) |-> measure_channel_valid == (measure_channel_sel <= 5'h08 ||
      (measure_channel_sel >= 5'h0f && measure_channel_sel <= 5'h11)))
      else $error("channel valid flag wrong");
   AST_INT_TEMP_SRC: assert property (reg_wr && reg_addr == 8'h3e && !reg_wdata[0] ##1 sensor_temp_valid |=>
      ##1 comp_temp == $past(sensor_temp, 2))
      else $error("compensation temperature not internal");
   AST_PUMP_FIELDS: assert property (reg_wr && reg_addr == 8'h76 ##1 !reg_wr |=>
      {pump_threshold, adaptive_hysteresis_en} == 3'($past(reg_wdata, 2) >> 5))
      else $error("pump threshold fields wrong");
   AST_PAGE_SEL: assert property (reg_wr && reg_addr == 8'h4f && reg_wdata < 8'h06 ##1 !reg_wr |=>
      code_page_sel == 3'($past(reg_wdata, 2)))
      else $error("page select wrong");
   COV_IRQ: cover property ($fell(irq_pin_oe_n));
   COV_DONE: cover property ($fell(measure_active));
   COV_CLEAR: cover property (st_rd && !irq_pin_oe_n);
endmodule
bind ltm_bank ltm_bank_monitor #(.MEAS_CYCLES(MEAS_CYCLES)) mon (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .sensor_temp_valid(sensor_temp_valid),
   .sensor_temp(sensor_temp), .comp_temp(comp_temp), .measure_channel_sel(measure_channel_sel),
   .measure_channel_valid(measure_channel_valid), .measure_active(measure_active), .code_page_sel(code_page_sel),
   .pump_threshold(pump_threshold), .adaptive_hysteresis_en(adaptive_hysteresis_en), .irq_pin_o(irq_pin_o),
   .irq_pin_oe_n(irq_pin_oe_n));

// ===== sim/ltm_host.sv
// Host model driving the byte register port
`timescale 1ns/100ps
module ltm_host (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // Released lines invert so a stale value never passes as fresh
   task automatic idle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      idle();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      d = reg_rdata;
      idle();
   endtask
endmodule

// ===== sim/ltm_bank_tb.sv
// Self-checking bench for the LED test register bank
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
   $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module ltm_bank_tb;
   localparam int MEAS = 20;
   logic clk, nrst, sensor_temp_valid, power_save;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sensor_temp, comp_temp, adc_code;
   logic reg_wr, reg_rd, measure_channel_valid, measure_active, adaptive_hysteresis_en, irq_pin_o, irq_pin_oe_n;
   logic [4:0] measure_channel_sel;
   logic [23:0] eng_local_var = 24'h8c41f0;
   logic [26:0] eng_output_map = {9'h100, 9'h05a, 9'h1a5};
   logic [20:0] eng_code_base;
   logic [2:0] code_page_sel;
   logic [71:0] led_pwm_in = {9{8'h80}};
   logic [71:0] led_pwm_out;
   logic [17:0] led_group_sel = 18'h00039;
   logic [1:0] factory_threshold = 2'h2;
   logic [1:0] pump_threshold;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   // Pull-up on the open-drain line
   wire irq_line = irq_pin_oe_n ? 1'b1 : irq_pin_o;
   ltm_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   ltm_bank #(.MEAS_CYCLES(MEAS)) DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sensor_temp_valid(sensor_temp_valid),
      .sensor_temp(sensor_temp), .comp_temp(comp_temp), .power_save(power_save), .adc_code(adc_code),
      .measure_channel_sel(measure_channel_sel), .measure_channel_valid(measure_channel_valid),
      .measure_active(measure_active), .eng_local_var(eng_local_var), .eng_output_map(eng_output_map),
      .eng_code_base(eng_code_base), .code_page_sel(code_page_sel), .led_pwm_in(led_pwm_in),
      .led_group_sel(led_group_sel), .led_pwm_out(led_pwm_out), .factory_threshold(factory_threshold),
      .pump_threshold(pump_threshold), .adaptive_hysteresis_en(adaptive_hysteresis_en), .irq_pin_o(irq_pin_o),
      .irq_pin_oe_n(irq_pin_oe_n));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      `CHK(nm, e, d)
   endtask
   task automatic wait_irq();
      for (int i = 0; i < 4 * MEAS && irq_line !== 1'b0; i++) @(negedge clk);
   endtask
   task automatic s_reset();
      `CHK("irq idle", 1'b1, irq_line)
      @(negedge clk);
      `CHK("factory thr", 2'h2, pump_threshold)
      rchk("gain rd", 8'h76, 8'h00);
   endtask
   task automatic s_temp();
      logic [7:0] wi [7] = '{8'h5a, 8'h7f, 8'h59, 8'hd9, 8'hd8, 8'h80, 8'h17};
      logic [7:0] wo [7] = '{8'h59, 8'h59, 8'h59, 8'hd9, 8'hd9, 8'hd9, 8'h17};
      host.wr(8'h3e, 8'h01);
      for (int i = 0; i < 7; i++) begin
         host.wr(8'h40, wi[i]);
         rchk("clamp", 8'h40, wo[i]);
      end
      `CHK("comp ext", 8'h17, comp_temp)
      sensor_temp = 8'hd8;
      host.wr(8'h3e, 8'h00);
      sensor_temp_valid = 1'b1;
      @(negedge clk);
      sensor_temp_valid = 1'b0;
      @(negedge clk);
      `CHK("comp int", 8'hd8, comp_temp)
      host.wr(8'h3f, 8'h00);
      rchk("int temp", 8'h3f, 8'hd8);
   endtask
   task automatic s_test();
      adc_code = 8'ha6;
      host.wr(8'h41, 8'hd1);
      wait_irq();
      `CHK("irq low", 1'b0, irq_line)
      `CHK("chan", 5'h11, measure_channel_sel)
      rchk("result", 8'h42, 8'ha6);
      rchk("done", 8'h3a, 8'h80);
      @(negedge clk);
      `CHK("irq clr", 1'b1, irq_line)
      rchk("done clr", 8'h3a, 8'h00);
      host.wr(8'h41, 8'h80);
      repeat (2) @(negedge clk);
      for (int i = 0; i < 2 * MEAS && measure_active === 1'b1; i++) @(negedge clk);
      `CHK("no irq", 1'b1, irq_line)
      rchk("done2", 8'h3a, 8'h80);
   endtask
   task automatic s_cont();
      host.wr(8'h41, 8'he0);
      wait_irq();
      rchk("done c", 8'h3a, 8'h80);
      repeat (2 * MEAS) @(negedge clk);
      `CHK("repeat", 1'b1, measure_active)
      power_save = 1'b1;
      for (int i = 0; i < 2 * MEAS && measure_active === 1'b1; i++) @(negedge clk);
      repeat (2) @(negedge clk);
      `CHK("ps stop", 1'b0, measure_active)
      host.wr(8'h41, 8'h00);
      power_save = 1'b0;
      rchk("done p", 8'h3a, 8'h80);
   endtask
   task automatic s_chan();
      logic [4:0] cc [9] = '{5'h00, 5'h08, 5'h09, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h1f};
      logic [8:0] ev = 9'b001110011;
      for (int i = 0; i < 9; i++) begin
         host.wr(8'h41, {3'h0, cc[i]});
         @(negedge clk);
         `CHK("chan valid", ev[i], measure_channel_valid)
      end
   endtask
   task automatic s_eng();
      for (int i = 0; i < 3; i++) begin
         rchk("var", 8'h45 + 8'(i), eng_local_var[8 * i +: 8]);
         rchk("map hi", 8'h70 + 8'(2 * i), {7'h00, eng_output_map[9 * i + 8]});
         rchk("map lo", 8'h71 + 8'(2 * i), eng_output_map[9 * i +: 8]);
      end
      host.wr(8'h45, 8'h00);
      rchk("var ro", 8'h45, 8'hf0);
      rchk("unmapped", 8'h50, 8'h00);
   endtask
   task automatic s_dim_code();
      host.wr(8'h48, 8'h80);
      host.wr(8'h49, 8'hff);
      host.wr(8'h4a, 8'h00);
      host.wr(8'h4c, 8'h85);
      host.wr(8'h4d, 8'h10);
      host.wr(8'h4e, 8'h7f);
      host.wr(8'h4f, 8'h05);
      @(negedge clk);
      `CHK("dims", 72'h8080808080_80007f40, led_pwm_out)
      `CHK("bases", {7'h7f, 7'h10, 7'h05}, eng_code_base)
      host.wr(8'h4f, 8'h06);
      host.wr(8'h4f, 8'h07);
      @(negedge clk);
      `CHK("page", 3'h5, code_page_sel)
      host.wr(8'h76, 8'he0);
      @(negedge clk);
      `CHK("thr", 3'h7, {pump_threshold, adaptive_hysteresis_en})
      rchk("gain", 8'h76, 8'he0);
   endtask
   task automatic complete_run();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         complete_run();
      end
   end
   initial begin
      nrst = 1'b0;
      sensor_temp_valid = 1'b0;
      sensor_temp = 8'h00;
      power_save = 1'b0;
      adc_code = 8'h00;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      s_reset();
      s_temp();
      s_test();
      s_cont();
      s_chan();
      s_eng();
      s_dim_code();
      complete_run();
   end
endmodule
